// file: design/cpt_pkg.sv
/*
 * constants for the capture / pwm / one-shot timer upper register set.
 * assumes an ahb-lite slave with 32-bit words, one register per word.
 */
package cpt_pkg;
    // ======================================================================
    // register indices (printed offsets are not word aligned: byte = 4*idx)
    // ======================================================================
    localparam logic [31:0] IDX_CAPTURE_LOW_IN1   = 32'h5000_0210;
    localparam logic [31:0] IDX_CAPTURE_LOW_IN2   = 32'h5000_0212;
    localparam logic [31:0] IDX_PRESCALER_NOW     = 32'h5000_0214;
    localparam logic [31:0] IDX_PWM_PERIOD        = 32'h5000_0216;
    localparam logic [31:0] IDX_PWM_DUTY          = 32'h5000_0218;
    localparam logic [31:0] IDX_COUNTER_UPPER_NOW = 32'h5000_021a;
    localparam logic [31:0] IDX_RELOAD_UPPER      = 32'h5000_021c;
    localparam logic [31:0] IDX_CAPTURE_UPPER_IN1 = 32'h5000_021e;
    localparam logic [31:0] IDX_CAPTURE_UPPER_IN2 = 32'h5000_0220;
    localparam logic [31:0] IDX_SHOT_WIDTH_UPPER  = 32'h5000_0222;
    // own registers
    localparam logic [31:0] IDX_CONTROL           = 32'h5000_0230;
    localparam logic [31:0] IDX_STATUS            = 32'h5000_0232;
    localparam logic [31:0] IDX_RELOAD_LOWER      = 32'h5000_0234;
    localparam logic [31:0] IDX_SHOT_WIDTH_LOWER  = 32'h5000_0236;
    localparam logic [31:0] IDX_COUNT_DIVIDER     = 32'h5000_0238;
    localparam logic [31:0] IDX_COUNTER_LOWER_NOW = 32'h5000_023a;
    localparam logic [31:0] IDX_EVENT_STATUS      = 32'h5000_023c;
    localparam logic [31:0] IDX_EVENT_MASK        = 32'h5000_023e;
    localparam int          IDX_SHIFT             = 2;
    localparam int          IDX_BITS              = 30;

    // ======================================================================
    // control and status fields
    // ======================================================================
    localparam int CTL_ENABLE    = 0;
    localparam int CTL_ONESHOT   = 1;
    localparam int CTL_COUNTDOWN = 2;
    localparam int CTL_IN1_FALL  = 3;
    localparam int CTL_IN2_FALL  = 4;
    localparam int CTL_FREERUN   = 6;
    localparam int CTL_FAST_CLK  = 7;
    localparam int CTL_WIDTH     = 8;
    localparam int STS_IN1_LEVEL = 0;
    localparam int STS_IN2_LEVEL = 1;
    localparam int STS_PHASE_LO  = 2;
    // event bits: capture 1, capture 2, counter wrap, shot end
    localparam int EVT_WIDTH     = 4;
    localparam int EVT_CAP1      = 0;
    localparam int EVT_CAP2      = 1;
    localparam int EVT_WRAP      = 2;
    localparam int EVT_SHOT_END  = 3;

    // ======================================================================
    // timing
    // ======================================================================
    localparam logic [31:0] SYNC_CYCLES = 32'h0000_0003;
    localparam int          HALF        = 16;
    localparam logic [1:0]  HTRANS_NSEQ = 2'h2;
    localparam logic [2:0]  HSIZE_WORD  = 3'h2;

    typedef enum logic [1:0] {
        CPT_WAIT  = 2'b00,
        CPT_DELAY = 2'b01,
        CPT_START = 2'b10,
        CPT_SHOT  = 2'b11
    } cpt_phase_t;
endpackage

// file: design/cpt_timer.sv
/*
 * capture / pwm / one-shot timer, ahb-lite slave.
 * assumes event inputs synchronous to hclk and a 32 khz tick strobe in hclk.
 */
// Implementation choice: the AHB-Lite register port.
`timescale 1ns/1ps
module cpt_timer (
    // clock and reset
    input  wire logic        hclk,
    input  wire logic        hresetn,
    // ahb-lite slave
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    // timer pins
    input  wire logic        slow_tick,
    input  wire logic        first_event_input,
    input  wire logic        second_event_input,
    output logic             pwm_out,
    output logic             shot_out,
    output logic             irq
);
    // ======================================================================
    // registers
    // ======================================================================
    logic [cpt_pkg::CTL_WIDTH-1:0] control;
    logic [15:0] pwm_period_setting, pwm_duty_setting;
    logic [15:0] reload_upper, reload_lower, shot_width_upper, shot_width_lower;
    logic [15:0] count_divider, prescaler_count_now;
    logic [31:0] counter, capture_in1, capture_in2;
    logic [15:0] pwm_count;
    logic [31:0] phase_count;
    logic [cpt_pkg::EVT_WIDTH-1:0] event_status, event_mask, event_set;
    logic        in1_prev, in2_prev;
    cpt_pkg::cpt_phase_t single_pulse_phase;

    logic        fast_clock_select, first_input_falling_select, second_input_falling_select;
    logic        tick, edge1, edge2, fire, wrap;
    logic [31:0] reload_full, shot_full;

    assign fast_clock_select           = control[cpt_pkg::CTL_FAST_CLK];
    assign first_input_falling_select  = control[cpt_pkg::CTL_IN1_FALL];
    assign second_input_falling_select = control[cpt_pkg::CTL_IN2_FALL];
    assign reload_full = {reload_upper, reload_lower};
    assign shot_full   = {shot_width_upper, shot_width_lower};

    // ======================================================================
    // bus slave
    // ======================================================================
    logic        ph_wr;
    logic [31:0] ph_idx, rd_idx;
    logic        wr_hit, rd_take;
    logic [31:0] next_rdata;

    // byte address carries 30 index bits; the top two come from the map window
    assign rd_idx  = {cpt_pkg::IDX_CONTROL[31:cpt_pkg::IDX_BITS], haddr[31:cpt_pkg::IDX_SHIFT]};
    assign rd_take = hready && hsel && htrans == cpt_pkg::HTRANS_NSEQ && !hwrite;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ph_wr  <= 1'b0;
            ph_idx <= 32'h0;
        end else if (hready) begin
            ph_wr  <= hsel && htrans == cpt_pkg::HTRANS_NSEQ && hwrite;
            ph_idx <= rd_idx;
        end else begin
            ph_wr <= 1'b0;
        end
    end

    assign wr_hit = ph_wr;

    always_comb begin
        case (rd_idx)
            cpt_pkg::IDX_CAPTURE_LOW_IN1:   next_rdata = {16'h0, capture_in1[15:0]};
            cpt_pkg::IDX_CAPTURE_LOW_IN2:   next_rdata = {16'h0, capture_in2[15:0]};
            cpt_pkg::IDX_PRESCALER_NOW:     next_rdata = {16'h0, prescaler_count_now};
            cpt_pkg::IDX_PWM_PERIOD:        next_rdata = {16'h0, pwm_period_setting};
            cpt_pkg::IDX_PWM_DUTY:          next_rdata = {16'h0, pwm_duty_setting};
            cpt_pkg::IDX_COUNTER_UPPER_NOW: next_rdata = {16'h0, counter[31:16]};
            cpt_pkg::IDX_RELOAD_UPPER:      next_rdata = {16'h0, reload_upper};
            cpt_pkg::IDX_CAPTURE_UPPER_IN1: next_rdata = {16'h0, capture_in1[31:16]};
            cpt_pkg::IDX_CAPTURE_UPPER_IN2: next_rdata = {16'h0, capture_in2[31:16]};
            cpt_pkg::IDX_SHOT_WIDTH_UPPER:  next_rdata = {16'h0, shot_width_upper};
            cpt_pkg::IDX_CONTROL:           next_rdata = {24'h0, control};
            cpt_pkg::IDX_STATUS:            next_rdata = {28'h0, single_pulse_phase,
                                                          in2_prev, in1_prev};
            cpt_pkg::IDX_RELOAD_LOWER:      next_rdata = {16'h0, reload_lower};
            cpt_pkg::IDX_SHOT_WIDTH_LOWER:  next_rdata = {16'h0, shot_width_lower};
            cpt_pkg::IDX_COUNT_DIVIDER:     next_rdata = {16'h0, count_divider};
            cpt_pkg::IDX_COUNTER_LOWER_NOW: next_rdata = {16'h0, counter[15:0]};
            cpt_pkg::IDX_EVENT_STATUS:      next_rdata = {28'h0, event_status};
            cpt_pkg::IDX_EVENT_MASK:        next_rdata = {28'h0, event_mask};
            default:                        next_rdata = 32'h0;
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata    <= 32'h0;
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end else begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
            // zero wait states: decode at the address phase, data stands in data phase
            if (rd_take) begin
                hrdata <= next_rdata;
            end
        end
    end

    // writable registers
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            control            <= '0;
            pwm_period_setting <= 16'h0;
            pwm_duty_setting   <= 16'h0;
            reload_upper       <= 16'h0;
            reload_lower       <= 16'h0;
            shot_width_upper   <= 16'h0;
            shot_width_lower   <= 16'h0;
            count_divider      <= 16'h0;
            event_mask         <= '0;
        end else if (wr_hit) begin
            case (ph_idx)
                cpt_pkg::IDX_CONTROL:          control <= hwdata[cpt_pkg::CTL_WIDTH-1:0];
                cpt_pkg::IDX_PWM_PERIOD:       pwm_period_setting <= hwdata[15:0];
                cpt_pkg::IDX_PWM_DUTY:         pwm_duty_setting   <= hwdata[15:0];
                cpt_pkg::IDX_RELOAD_UPPER:     reload_upper       <= hwdata[15:0];
                cpt_pkg::IDX_RELOAD_LOWER:     reload_lower       <= hwdata[15:0];
                cpt_pkg::IDX_SHOT_WIDTH_UPPER: shot_width_upper   <= hwdata[15:0];
                cpt_pkg::IDX_SHOT_WIDTH_LOWER: shot_width_lower   <= hwdata[15:0];
                cpt_pkg::IDX_COUNT_DIVIDER:    count_divider      <= hwdata[15:0];
                cpt_pkg::IDX_EVENT_MASK:       event_mask <= hwdata[cpt_pkg::EVT_WIDTH-1:0];
                default: ;
            endcase
        end
    end

    // ======================================================================
    // prescaler and counter
    // ======================================================================
    logic src_tick;
    assign src_tick = fast_clock_select ? 1'b1 : slow_tick;
    assign tick = control[cpt_pkg::CTL_ENABLE] && src_tick
                  && prescaler_count_now == count_divider;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            prescaler_count_now <= 16'h0;
        end else if (!control[cpt_pkg::CTL_ENABLE] || tick) begin
            prescaler_count_now <= 16'h0;
        end else if (src_tick) begin
            prescaler_count_now <= prescaler_count_now + 16'h1;
        end
    end

    assign wrap = tick && !control[cpt_pkg::CTL_ONESHOT] &&
                  (control[cpt_pkg::CTL_COUNTDOWN] ? counter == 32'h0 :
                   control[cpt_pkg::CTL_FREERUN] ? counter == 32'hffff_ffff :
                   counter == reload_full);

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            counter <= 32'h0;
        end else if (!control[cpt_pkg::CTL_ENABLE] || control[cpt_pkg::CTL_ONESHOT]) begin
            counter <= 32'h0;
        end else if (wrap) begin
            counter <= control[cpt_pkg::CTL_COUNTDOWN] ? reload_full : 32'h0;
        end else if (tick) begin
            counter <= control[cpt_pkg::CTL_COUNTDOWN] ? counter - 32'h1 : counter + 32'h1;
        end
    end

    // ======================================================================
    // edge detect and capture
    // ======================================================================
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            in1_prev <= 1'b0;
            in2_prev <= 1'b0;
        end else begin
            in1_prev <= first_event_input;
            in2_prev <= second_event_input;
        end
    end

    assign edge1 = first_input_falling_select ? (in1_prev && !first_event_input)
                                              : (!in1_prev && first_event_input);
    assign edge2 = second_input_falling_select ? (in2_prev && !second_event_input)
                                               : (!in2_prev && second_event_input);

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            capture_in1 <= 32'h0;
            capture_in2 <= 32'h0;
        end else if (control[cpt_pkg::CTL_ENABLE]) begin
            if (edge1) capture_in1 <= counter;
            if (edge2) capture_in2 <= counter;
        end
    end

    // ======================================================================
    // one-shot
    // ======================================================================
    assign fire = control[cpt_pkg::CTL_ENABLE] && control[cpt_pkg::CTL_ONESHOT] && edge1;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            single_pulse_phase <= cpt_pkg::CPT_WAIT;
            phase_count        <= 32'h0;
            shot_out           <= 1'b0;
        end else if (!control[cpt_pkg::CTL_ENABLE] || !control[cpt_pkg::CTL_ONESHOT]) begin
            single_pulse_phase <= cpt_pkg::CPT_WAIT;
            phase_count        <= 32'h0;
            shot_out           <= 1'b0;
        end else begin
            case (single_pulse_phase)
                cpt_pkg::CPT_WAIT: begin
                    if (fire) begin
                        single_pulse_phase <= cpt_pkg::CPT_DELAY;
                        phase_count        <= 32'h1;
                    end
                end
                cpt_pkg::CPT_DELAY: begin
                    // edge cycle counts as first sync cycle
                    if (phase_count >= reload_full + cpt_pkg::SYNC_CYCLES - 32'h1) begin
                        single_pulse_phase <= cpt_pkg::CPT_START;
                        phase_count        <= 32'h0;
                    end else begin
                        phase_count <= phase_count + 32'h1;
                    end
                end
                cpt_pkg::CPT_START: begin
                    single_pulse_phase <= cpt_pkg::CPT_SHOT;
                    shot_out           <= 1'b1;
                end
                cpt_pkg::CPT_SHOT: begin
                    if (tick && phase_count >= shot_full) begin
                        single_pulse_phase <= cpt_pkg::CPT_WAIT;
                        shot_out           <= 1'b0;
                    end else if (tick) begin
                        phase_count <= phase_count + 32'h1;
                    end
                end
                default: single_pulse_phase <= cpt_pkg::CPT_WAIT;
            endcase
        end
    end

    // ======================================================================
    // pwm
    // ======================================================================
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pwm_count <= 16'h0;
            pwm_out   <= 1'b0;
        end else if (!control[cpt_pkg::CTL_ENABLE]) begin
            pwm_count <= 16'h0;
            pwm_out   <= 1'b0;
        end else if (tick) begin
            pwm_count <= (pwm_count >= pwm_period_setting) ? 16'h0
                         : pwm_count + 16'h1;
            pwm_out   <= ((pwm_count >= pwm_period_setting) ? 16'h0 : pwm_count + 16'h1)
                         < pwm_duty_setting;
        end
    end

    // ======================================================================
    // interrupts
    // ======================================================================
    always_comb begin
        event_set = '0;
        event_set[cpt_pkg::EVT_CAP1]     = control[cpt_pkg::CTL_ENABLE] && edge1;
        event_set[cpt_pkg::EVT_CAP2]     = control[cpt_pkg::CTL_ENABLE] && edge2;
        event_set[cpt_pkg::EVT_WRAP]     = wrap;
        event_set[cpt_pkg::EVT_SHOT_END] = shot_out && single_pulse_phase == cpt_pkg::CPT_SHOT
                                           && tick && phase_count >= shot_full;
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            event_status <= '0;
        end else begin
            // set wins over write-one-to-clear
            event_status <= (event_status & ~((wr_hit && ph_idx == cpt_pkg::IDX_EVENT_STATUS)
                            ? hwdata[cpt_pkg::EVT_WIDTH-1:0] : '0)) | event_set;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) irq <= 1'b0;
        else          irq <= |(event_status & event_mask);
    end

    // ======================================================================
    // checks
    // ======================================================================
    a_capture_both_halves: assert property (@(posedge hclk) disable iff (!hresetn)
        control[cpt_pkg::CTL_ENABLE] && edge1 |=> capture_in1 == $past(counter))
        else $error("capture 1 not latched from counter");
    a_capture_second: assert property (@(posedge hclk) disable iff (!hresetn)
        control[cpt_pkg::CTL_ENABLE] && edge2 |=> capture_in2 == $past(counter))
        else $error("capture 2 not latched from counter");
    a_prescaler_bound: assert property (@(posedge hclk) disable iff (!hresetn)
        prescaler_count_now <= count_divider || $past(wr_hit))
        else $error("prescaler beyond divider");
    a_counter_hold: assert property (@(posedge hclk) disable iff (!hresetn)
        !tick && !$past(wr_hit) && control[cpt_pkg::CTL_ENABLE]
        && !control[cpt_pkg::CTL_ONESHOT] |=> $stable(counter))
        else $error("counter moved without tick");
    a_pwm_count_range: assert property (@(posedge hclk) disable iff (!hresetn)
        tick && pwm_count == pwm_period_setting |=> pwm_count == 16'h0)
        else $error("pwm period did not restart");
    a_pwm_zero_duty: assert property (@(posedge hclk) disable iff (!hresetn)
        tick && pwm_duty_setting == 16'h0 && $stable(pwm_duty_setting) |=> !pwm_out)
        else $error("pwm high with zero duty");
    sequence s_fire_zero;
        fire && single_pulse_phase == cpt_pkg::CPT_WAIT && reload_full == 32'h0;
    endsequence
    a_delay_sync: assert property (@(posedge hclk) disable iff (!hresetn)
        s_fire_zero ##1 (control[cpt_pkg::CTL_ENABLE] && control[cpt_pkg::CTL_ONESHOT]
            && !wr_hit)[*2]
        |=> single_pulse_phase == cpt_pkg::CPT_START)
        else $error("delay phase length wrong");
    a_edge_polarity: assert property (@(posedge hclk) disable iff (!hresetn)
        edge1 |-> first_event_input == !first_input_falling_select)
        else $error("capture edge polarity wrong");
    a_irq_level: assert property (@(posedge hclk) disable iff (!hresetn)
        |(event_status & event_mask) |=> irq)
        else $error("irq missing");
    a_shot_level: assert property (@(posedge hclk) disable iff (!hresetn)
        shot_out == (single_pulse_phase == cpt_pkg::CPT_SHOT))
        else $error("shot output disagrees with phase");
    a_period_write: assert property (@(posedge hclk) disable iff (!hresetn)
        wr_hit && ph_idx == cpt_pkg::IDX_PWM_PERIOD |=> pwm_period_setting == $past(hwdata[15:0]))
        else $error("pwm period write lost");
    a_reload_write: assert property (@(posedge hclk) disable iff (!hresetn)
        wr_hit && ph_idx == cpt_pkg::IDX_RELOAD_UPPER |=> reload_upper == $past(hwdata[15:0]))
        else $error("reload upper write lost");
    a_width_write: assert property (@(posedge hclk) disable iff (!hresetn)
        wr_hit && ph_idx == cpt_pkg::IDX_SHOT_WIDTH_UPPER
        |=> shot_width_upper == $past(hwdata[15:0]))
        else $error("shot width upper write lost");
    a_prescaler_read: assert property (@(posedge hclk) disable iff (!hresetn)
        rd_take && rd_idx == cpt_pkg::IDX_PRESCALER_NOW
        |=> hrdata == {16'h0, $past(prescaler_count_now)})
        else $error("prescaler readback wrong");
    a_upper_read: assert property (@(posedge hclk) disable iff (!hresetn)
        rd_take && rd_idx == cpt_pkg::IDX_COUNTER_UPPER_NOW
        |=> hrdata == {16'h0, $past(counter[31:16])})
        else $error("counter upper readback wrong");
endmodule

// file: tb/cpt_evt_src.sv
/* event source model: two event lines and the slow tick strobe.
   assumes the bench sets the wanted levels; all in the hclk domain. */
`timescale 1ns/1ps
module cpt_evt_src #(parameter int TICK_DIV = 8) (
    // clock and reset
    input  wire logic hclk,
    input  wire logic hresetn,
    // wanted levels
    input  wire logic want1,
    input  wire logic want2,
    // lines to the timer
    output logic      ev1,
    output logic      ev2,
    output logic      tick
);
    int cnt;
    // pins move one edge after the request
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) {ev1, ev2} <= 2'h0;
        else {ev1, ev2} <= {want1, want2};
    end
    // one-cycle strobe per slow period
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) cnt <= 0;
        else cnt <= (cnt == TICK_DIV - 1) ? 0 : cnt + 1;
    end
    assign tick = (cnt == TICK_DIV - 1);
endmodule

// file: tb/cpt_tb.sv
/* bench for cpt_timer: registers, rates, pwm, capture, irq, one-shot.
   assumes cpt_evt_src drives the event lines and the slow tick. */
`timescale 1ns/1ps
module capture_pwm_oneshot_timer_upper_tb;
    typedef struct {logic [31:0] idx; logic rw;} cpt_row_t;
    logic        hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, want1 = 0, want2 = 0;
    logic [1:0]  htrans = 0;
    logic [31:0] haddr = 0, hwdata = 0, hrdata, rd, a, b;
    logic        hreadyout, hresp, ev1, ev2, tick, pwm_out, shot_out, irq;
    int          n_mismatch = 0, tests_run = 0, cyc = 0, c;
    int          dl[3] = '{0, 2, 5};
    cpt_row_t    rows[11] = '{'{cpt_pkg::IDX_CAPTURE_LOW_IN1, 0}, '{cpt_pkg::IDX_CAPTURE_LOW_IN2, 0},
        '{cpt_pkg::IDX_PRESCALER_NOW, 0}, '{cpt_pkg::IDX_PWM_PERIOD, 1},
        '{cpt_pkg::IDX_PWM_DUTY, 1}, '{cpt_pkg::IDX_COUNTER_UPPER_NOW, 0},
        '{cpt_pkg::IDX_RELOAD_UPPER, 1}, '{cpt_pkg::IDX_CAPTURE_UPPER_IN1, 0},
        '{cpt_pkg::IDX_CAPTURE_UPPER_IN2, 0}, '{cpt_pkg::IDX_SHOT_WIDTH_UPPER, 1},
        '{32'h5000_0300, 0}};
    always #2.5 hclk = ~hclk;
    cpt_timer cpt_timer_inst (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(cpt_pkg::HSIZE_WORD), .hwdata(hwdata),
        .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .slow_tick(tick), .first_event_input(ev1), .second_event_input(ev2),
        .pwm_out(pwm_out), .shot_out(shot_out), .irq(irq));
    cpt_evt_src cpt_evt_src_inst (.hclk(hclk), .hresetn(hresetn), .want1(want1),
        .want2(want2), .ev1(ev1), .ev2(ev2), .tick(tick));
    // ======================================================================
    // bus and check tasks
    // ======================================================================
    task automatic bus(input logic w, input logic [31:0] idx, input logic [31:0] wd);
        haddr <= idx << cpt_pkg::IDX_SHIFT;
        hwrite <= w;
        htrans <= cpt_pkg::HTRANS_NSEQ;
        hsel <= 1'b1;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        htrans <= 2'h0;
        hwdata <= wd;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        rd = hrdata;
        chk("hresp", 0, hresp);
    endtask
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        tests_run++;
        if (e !== g) begin
            n_mismatch++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic close_out;
        $display("checks %0d mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    always @(posedge hclk) begin
        cyc++;
        if (cyc == 30000) begin
            n_mismatch++;
            close_out();
        end
    end
    // ======================================================================
    // scenarios
    // ======================================================================
    initial begin
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        foreach (rows[i]) begin
            bus(0, rows[i].idx, 0);
            chk("reset value", 0, rd);
            bus(1, rows[i].idx, 32'hffff_a5a5);
            bus(0, rows[i].idx, 0);
            chk("access", rows[i].rw ? 32'h0000_a5a5 : 32'h0, rd);
        end
        // slow tick with divider 0, then fast clock with divider 3
        for (int k = 0; k < 2; k++) begin
            bus(1, cpt_pkg::IDX_COUNT_DIVIDER, k ? 3 : 0);
            bus(1, cpt_pkg::IDX_CONTROL, k ? 32'hc1 : 32'h41);
            bus(0, cpt_pkg::IDX_PRESCALER_NOW, 0);
            chk("prescaler", 1, 32'(rd[15:0] <= (k ? 3 : 0)));
            bus(0, cpt_pkg::IDX_COUNTER_LOWER_NOW, 0);
            a = rd;
            repeat (40) @(posedge hclk);
            bus(0, cpt_pkg::IDX_COUNTER_LOWER_NOW, 0);
            c = int'(rd[15:0] - a[15:0]);
            chk("rate", 1, 32'(c == (k ? 10 : 5) || c == (k ? 11 : 6)));
        end
        bus(1, cpt_pkg::IDX_PWM_PERIOD, 4);
        foreach (dl[j]) begin
            bus(1, cpt_pkg::IDX_PWM_DUTY, dl[j]);
            repeat (40) @(posedge hclk);
            c = 0;
            repeat (100) begin
                @(posedge hclk);
                c += (pwm_out === 1'b1);
            end
            chk("pwm high", dl[j] * 20, c);
        end
        bus(1, cpt_pkg::IDX_RELOAD_UPPER, 2);
        bus(1, cpt_pkg::IDX_RELOAD_LOWER, 0);
        bus(1, cpt_pkg::IDX_EVENT_MASK, 3);
        bus(1, cpt_pkg::IDX_CONTROL, 32'h85);
        c = 0;
        do begin
            bus(0, cpt_pkg::IDX_COUNTER_UPPER_NOW, 0);
            c++;
        end while (rd !== 32'h1 && c < 2000);
        chk("counter upper", 1, rd);
        want1 <= 1'b1;
        repeat (8) @(posedge hclk);
        want2 <= 1'b1;
        repeat (4) @(posedge hclk);
        bus(0, cpt_pkg::IDX_CAPTURE_UPPER_IN1, 0);
        a[31:16] = rd[15:0];
        bus(0, cpt_pkg::IDX_CAPTURE_LOW_IN1, 0);
        a[15:0] = rd[15:0];
        bus(0, cpt_pkg::IDX_CAPTURE_UPPER_IN2, 0);
        b[31:16] = rd[15:0];
        bus(0, cpt_pkg::IDX_CAPTURE_LOW_IN2, 0);
        b[15:0] = rd[15:0];
        chk("capture upper", 32'h0001_0001, {a[31:16], b[31:16]});
        chk("capture gap", 2, a - b);
        chk("irq set", 1, irq);
        bus(1, cpt_pkg::IDX_EVENT_STATUS, 3);
        bus(0, cpt_pkg::IDX_EVENT_STATUS, 0);
        chk("status clear", 0, rd[1:0]);
        bus(1, cpt_pkg::IDX_EVENT_MASK, 0);
        repeat (2) @(posedge hclk);
        chk("irq clear", 0, irq);
        bus(1, cpt_pkg::IDX_CONTROL, 32'h9d);
        for (int k = 0; k < 2; k++) begin
            bus(1, cpt_pkg::IDX_EVENT_STATUS, 32'hf);
            want1 <= k[0];
            want2 <= k[0];
            repeat (4) @(posedge hclk);
            bus(0, cpt_pkg::IDX_EVENT_STATUS, 0);
            chk("falling select", k ? 0 : 3, rd[1:0]);
            chk("irq masked", 0, irq);
        end
        want1 <= 1'b0;
        bus(1, cpt_pkg::IDX_RELOAD_LOWER, 16);
        bus(1, cpt_pkg::IDX_RELOAD_UPPER, 0);
        bus(1, cpt_pkg::IDX_SHOT_WIDTH_LOWER, 5);
        bus(1, cpt_pkg::IDX_SHOT_WIDTH_UPPER, 0);
        bus(1, cpt_pkg::IDX_CONTROL, 32'h83);
        want1 <= 1'b1;
        repeat (4) @(posedge hclk);
        bus(0, cpt_pkg::IDX_STATUS, 0);
        chk("phase delay", 1, rd[3:2]);
        for (c = 6; shot_out !== 1'b1 && c < 200; c++) @(posedge hclk);
        chk("delay", 1, 32'(c >= 19 && c <= 26));
        bus(0, cpt_pkg::IDX_STATUS, 0);
        chk("phase shot", 3, rd[3:2]);
        for (c = 2; shot_out === 1'b1 && c < 200; c++) @(posedge hclk);
        chk("shot", 1, 32'(c >= 21 && c <= 24));
        close_out();
    end
endmodule
